// ==== hdl/pit_timer_flags.sv ====
// Periodic tick generator with timer flag, mask and accumulator control registers
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pit_consts.svh"

module pit_timer_flags (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire pit_pkg::pit_wb_req_t i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_synth_supply_sense,
  input wire logic i_normal_mode,
  input wire logic i_chain_tap_pulse,
  input wire logic i_modulus_underflow,
  input wire logic i_counter_wrap,
  input wire logic i_accum_wrap,
  input wire logic i_accum_edge,
  output logic o_periodic_tick,
  output pit_pkg::pit_irq_t o_irq,
  output pit_pkg::pit_ctrl_t o_ctrl
);
  import pit_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [5:0] tick_last(input logic synth, input logic [1:0] rate);
    logic [5:0] r;
    r = 6'h00;
    case (rate)
      2'h0: r = 6'h00;
      2'h1: r = 6'h01;
      2'h2: r = 6'h03;
      default: r = synth ? `PIT_DIV_MAX_MOD : `PIT_DIV_MAX_CHAIN;
    endcase
    return r;
  endfunction

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] idx);
    return adr == {idx[5:0], 2'h0};
  endfunction

  logic [7:0] mask_reg;
  logic [7:0] flags_reg;
  logic [7:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic sense_meta_reg;
  logic sense_reg;
  logic [5:0] div_cnt_reg;
  logic tick_reg;
  logic [6:0] age_reg;
  logic presc_done_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic acc;
  logic wr_mask;
  logic wr_flags;
  logic wr_ctrl;
  logic presc_open;
  logic [7:0] wdat;
  logic [7:0] flag_set;
  logic hit_mask;
  logic hit_flags;
  logic hit_ctrl;

  assign acc = i_wb.cyc && i_wb.stb && !ack_reg;
  assign wdat = i_wb.dat[7:0];
  assign hit_mask = reg_hit(i_wb.adr, `PIT_IDX_MASK);
  assign hit_flags = reg_hit(i_wb.adr, `PIT_IDX_FLAGS);
  assign hit_ctrl = reg_hit(i_wb.adr, `PIT_IDX_CTRL);
  assign wr_mask = acc && i_wb.we && i_wb.sel[0] && hit_mask;
  assign wr_flags = acc && i_wb.we && i_wb.sel[0] && hit_flags;
  assign wr_ctrl = acc && i_wb.we && i_wb.sel[0] && hit_ctrl;
  assign presc_open = !i_normal_mode || (!presc_done_reg && (age_reg < `PIT_PRESC_WINDOW));

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= acc;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unmapped addresses answer with zero
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdat_reg <= 32'h0000_0000;
    end else if (acc) begin
      if (hit_mask) begin
        rdat_reg <= {24'h00_0000, mask_reg & `PIT_MASK_IMPL};
      end else if (hit_flags) begin
        rdat_reg <= {24'h00_0000, flags_reg & `PIT_FLAGS_IMPL};
      end else if (hit_ctrl) begin
        rdat_reg <= {24'h00_0000, ctrl_reg & `PIT_CTRL_IMPL};
      end else begin
        rdat_reg <= 32'h0000_0000;
      end
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = rdat_reg;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      age_reg <= 7'h00;
    end else if (age_reg < `PIT_PRESC_WINDOW) begin
      age_reg <= age_reg + 7'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mask_reg <= `PIT_RESET_VAL;
      presc_done_reg <= 1'b0;
    end else if (wr_mask) begin
      mask_reg[7:4] <= wdat[7:4];
      if (presc_open) begin
        mask_reg[1:0] <= wdat[1:0];
        presc_done_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ctrl_reg <= `PIT_RESET_VAL;
    end else if (wr_ctrl) begin
      ctrl_reg <= wdat & `PIT_CTRL_IMPL;
    end
  end

  assign flag_set = {i_counter_wrap, tick_reg, i_accum_wrap, i_accum_edge, 4'h0};

  // Set beats a clearing write
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      flags_reg <= `PIT_RESET_VAL;
    end else begin
      flags_reg <= ((flags_reg & ~(wr_flags ? wdat : 8'h00)) | flag_set) & `PIT_FLAGS_IMPL;
    end
  end

  // ----------------------------------------
  // Tick source and divider
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      sense_meta_reg <= 1'b0;
      sense_reg <= 1'b0;
    end else begin
      sense_meta_reg <= i_synth_supply_sense;
      sense_reg <= sense_meta_reg;
    end
  end

  logic tick_src;
  logic [5:0] div_last;

  // Chain tap is taken before the main prescaler
  assign tick_src = sense_reg ? i_modulus_underflow : i_chain_tap_pulse;
  assign div_last = tick_last(sense_reg, ctrl_reg[1:0]);

  // Free-running period; flag clears do not touch it
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      div_cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (tick_src) begin
        if (div_cnt_reg >= div_last) begin
          div_cnt_reg <= 6'h00;
          tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign o_periodic_tick = tick_reg;
  assign o_irq.counter_wrap = flags_reg[`PIT_BIT_WRAP] && mask_reg[`PIT_BIT_WRAP];
  assign o_irq.periodic_tick = flags_reg[`PIT_BIT_TICK] && mask_reg[`PIT_BIT_TICK];
  assign o_irq.accum_wrap = flags_reg[`PIT_BIT_AWRAP] && mask_reg[`PIT_BIT_AWRAP];
  assign o_irq.accum_edge = flags_reg[`PIT_BIT_AEDGE] && mask_reg[`PIT_BIT_AEDGE];
  assign o_ctrl.accum_enable = ctrl_reg[`PIT_BIT_ACC_EN];
  assign o_ctrl.accum_gated_select = ctrl_reg[`PIT_BIT_GATED];
  assign o_ctrl.accum_edge_polarity = ctrl_reg[`PIT_BIT_POL];
  assign o_ctrl.fourth_input_capture = ctrl_reg[`PIT_BIT_CAP4];
  assign o_ctrl.main_prescale_select = mask_reg[1:0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_wrap_sets_flag: assert property (
    i_counter_wrap |=> flags_reg[`PIT_BIT_WRAP])
    else $error("wrap did not set flag");

  a_w1c_clears: assert property (
    wr_flags && wdat[`PIT_BIT_TICK] && !tick_reg |=> !flags_reg[`PIT_BIT_TICK])
    else $error("write one did not clear tick flag");

  a_zero_keeps: assert property (
    wr_flags && !wdat[`PIT_BIT_WRAP] && flags_reg[`PIT_BIT_WRAP] |=> flags_reg[`PIT_BIT_WRAP])
    else $error("zero write cleared flag");

  a_set_wins_clear: assert property (
    wr_flags && wdat[`PIT_BIT_WRAP] && i_counter_wrap |=> flags_reg[`PIT_BIT_WRAP])
    else $error("set lost to clear");

  a_flags_low_zero: assert property (
    ack_reg && $past(hit_flags) |-> rdat_reg[3:0] == 4'h0)
    else $error("flag low bits not zero");

  a_mask_rsvd_zero: assert property (
    ack_reg && $past(hit_mask) |-> rdat_reg[3:2] == 2'h0)
    else $error("mask reserved bits not zero");

  a_ctrl_rsvd_zero: assert property (
    ack_reg && $past(hit_ctrl) |-> !rdat_reg[7] && !rdat_reg[3])
    else $error("control reserved bits not zero");

  a_irq_wrap_level: assert property (
    i_counter_wrap && mask_reg[`PIT_BIT_WRAP] && !wr_mask |=> o_irq.counter_wrap)
    else $error("wrap request mismatch");

  a_irq_tick_level: assert property (
    tick_reg && mask_reg[`PIT_BIT_TICK] && !wr_mask |=> o_irq.periodic_tick)
    else $error("tick request missing");

  a_irq_follows: assert property (
    o_irq.periodic_tick && wr_flags && wdat[6] && !tick_reg |=> !o_irq.periodic_tick)
    else $error("tick request stuck after clear");

  a_tick_sets_flag: assert property (
    tick_reg |=> flags_reg[`PIT_BIT_TICK])
    else $error("tick did not set flag");

  a_tick_on_count: assert property (
    tick_reg |-> $past(tick_src) && $past(div_cnt_reg) >= $past(div_last) && div_cnt_reg == 6'h00)
    else $error("tick off its count");

  a_div_mod_long: assert property (
    sense_reg && ctrl_reg[1:0] == 2'h3 |-> div_last == 6'h3f)
    else $error("modulus divide wrong");

  a_div_chain_long: assert property (
    !sense_reg && ctrl_reg[1:0] == 2'h3 |-> div_last == 6'h07)
    else $error("chain divide wrong");

  a_src_select: assert property (
    !sense_reg && !i_chain_tap_pulse |=> !tick_reg)
    else $error("tick without chain pulse");

  a_tick_free_run: assert property (
    wr_flags && !tick_src |=> $stable(div_cnt_reg))
    else $error("flag clear moved period");

  a_reset_zero: assert property (
    $past(!i_nrst) |-> mask_reg == 8'h00 && flags_reg == 8'h00 && ctrl_reg == 8'h00)
    else $error("register not zero after reset");

  a_presc_locked: assert property (
    i_normal_mode && (presc_done_reg || age_reg == `PIT_PRESC_WINDOW) && wr_mask
    |=> $stable(mask_reg[1:0]))
    else $error("prescale changed after lock");

  a_accum_wrap_set: assert property (
    i_accum_wrap |=> flags_reg[`PIT_BIT_AWRAP])
    else $error("accumulator wrap lost");

  a_ack_one_cycle: assert property (
    ack_reg |=> !ack_reg)
    else $error("ack held");

  // ----------------------------------------
  // Assertions on masks, sources and bus
  // ----------------------------------------
  a_src_modulus: assert property (
    sense_reg && !i_modulus_underflow |=> !tick_reg)
    else $error("tick without modulus pulse");

  a_edge_sets_flag: assert property (
    i_accum_edge |=> flags_reg[`PIT_BIT_AEDGE])
    else $error("accumulator edge lost");

  a_irq_accum_wrap: assert property (
    i_accum_wrap && mask_reg[`PIT_BIT_AWRAP] && !wr_mask |=> o_irq.accum_wrap)
    else $error("accumulator wrap request missing");

  a_irq_accum_edge: assert property (
    i_accum_edge && mask_reg[`PIT_BIT_AEDGE] && !wr_mask |=> o_irq.accum_edge)
    else $error("accumulator edge request missing");

  a_mask_gates_irq: assert property (
    wr_mask && !wdat[`PIT_BIT_AEDGE] |=> !o_irq.accum_edge)
    else $error("masked edge request raised");

  a_irq_drop_mask: assert property (
    wr_mask && !wdat[`PIT_BIT_WRAP] |=> !o_irq.counter_wrap)
    else $error("wrap request stuck after mask clear");

  a_ctrl_write: assert property (
    wr_ctrl |=> ctrl_reg[1:0] == $past(wdat[1:0]))
    else $error("rate field not written");

  a_ctrl_rsvd_store: assert property (
    wr_ctrl |=> !ctrl_reg[7] && !ctrl_reg[3])
    else $error("control reserved bits stored");

  a_presc_open_write: assert property (
    wr_mask && presc_open |=> mask_reg[1:0] == $past(wdat[1:0]))
    else $error("prescale write lost in window");

  a_age_stops: assert property (
    age_reg == `PIT_PRESC_WINDOW |=> age_reg == `PIT_PRESC_WINDOW)
    else $error("window counter moved after expiry");

  a_rate_one: assert property (
    tick_src && ctrl_reg[1:0] == 2'h0 |=> tick_reg)
    else $error("divide by one missed a tick");

  a_chain_rate_two: assert property (
    !sense_reg && ctrl_reg[1:0] == 2'h1 |-> div_last == 6'h01)
    else $error("chain divide by two wrong");

  a_mod_rate_four: assert property (
    sense_reg && ctrl_reg[1:0] == 2'h2 |-> div_last == 6'h03)
    else $error("modulus divide by four wrong");

  a_flag_clear_any: assert property (
    wr_flags && wdat[`PIT_BIT_AWRAP] && !i_accum_wrap |=> !flags_reg[`PIT_BIT_AWRAP])
    else $error("write one did not clear accumulator flag");

  a_wrap_flag_holds: assert property (
    flags_reg[`PIT_BIT_WRAP] && !(wr_flags && wdat[`PIT_BIT_WRAP]) |=> flags_reg[`PIT_BIT_WRAP])
    else $error("wrap flag cleared without write");

  a_ack_needs_req: assert property (
    ack_reg |-> $past(i_wb.cyc) && $past(i_wb.stb))
    else $error("ack without request");

  a_rdat_upper_zero: assert property (
    o_wb_dat[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_sel_ignored: assert property (
    acc && i_wb.we && !i_wb.sel[0] |=> $stable(ctrl_reg))
    else $error("write without byte select landed");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_tick_irq: cover property (o_irq.periodic_tick);
  c_set_wins: cover property (wr_flags && wdat[7] && i_counter_wrap);
  c_presc_write: cover property (wr_mask && presc_open);
  c_mod_tick: cover property (sense_reg && tick_reg && ctrl_reg[1:0] == 2'h3);
  c_chain_tick: cover property (!sense_reg && tick_reg && ctrl_reg[1:0] == 2'h3);

endmodule
`default_nettype wire

// ==== hdl/pit_consts.svh ====
// Offsets, field positions, reset values and counts for the tick and flag block
//
// Notes on behaviour
// - Counter wrap sets flag bit 7
// - Writing one clears flag; only those bits
// - Flag bits 3..0 read as zero
// - Mask bits 3 and 2 read zero
// - Control bits 7 and 3 read zero
// - Upper mask bits gate matching flags
// - Wrap flag and enable raise wrap request
// - Tick flag and enable raise tick request
// - Supply low: tick from chain tap
// - Supply high: tick from modulus underflow
// - Chain source divided by 1,2,4,8
// - Modulus source divided by 1,2,4,64
// - Period runs from previous timeout, free
// - Every timeout sets tick flag bit 6
// - First flag after one full period
// - Rate field in control bits 1..0
// - Chain tap ahead of main prescaler
// - Control bit 2 picks capture or compare
// - Control bit 6 enables accumulator
// - Bit 5 gated mode, bit 4 edge
// - All three registers reset to zero
// - Prescale writable once, within 64 cycles, in normal mode
// - Accumulator rollover sets flag bit 5
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH

`define PIT_IDX_MASK 8'h24
`define PIT_IDX_FLAGS 8'h25
`define PIT_IDX_CTRL 8'h26
`define PIT_MASK_IMPL 8'hf3
`define PIT_FLAGS_IMPL 8'hf0
`define PIT_CTRL_IMPL 8'h77
`define PIT_RESET_VAL 8'h00
`define PIT_BIT_WRAP 7
`define PIT_BIT_TICK 6
`define PIT_BIT_AWRAP 5
`define PIT_BIT_AEDGE 4
`define PIT_BIT_ACC_EN 6
`define PIT_BIT_GATED 5
`define PIT_BIT_POL 4
`define PIT_BIT_CAP4 2
`define PIT_PRESC_WINDOW 7'h40
`define PIT_DIV_MAX_CHAIN 6'h07
`define PIT_DIV_MAX_MOD 6'h3f

`endif

// ==== hdl/pit_pkg.sv ====
// Types shared by the tick and flag block
package pit_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pit_wb_req_t;

  typedef struct packed {
    logic counter_wrap;
    logic periodic_tick;
    logic accum_wrap;
    logic accum_edge;
  } pit_irq_t;

  typedef struct packed {
    logic accum_enable;
    logic accum_gated_select;
    logic accum_edge_polarity;
    logic fourth_input_capture;
    logic [1:0] main_prescale_select;
  } pit_ctrl_t;

endpackage

// ==== dv/pit_tb.sv ====
// Self-checking testbench for the tick and flag block
`timescale 1ns/1ps
`default_nettype none
`include "pit_consts.svh"
module tb;
  import pit_pkg::*;
  logic clk, nrst, sense, nmode, tap, mdl, cw, aw, ae, ack, tick;
  pit_wb_req_t wb;
  logic [31:0] dat;
  pit_irq_t irq;
  pit_ctrl_t ctl;
  logic [7:0] rd;
  int err_count, checks;

  pit_timer_flags dut_u (.i_clk(clk), .i_nrst(nrst), .i_wb(wb), .o_wb_ack(ack), .o_wb_dat(dat),
    .i_synth_supply_sense(sense), .i_normal_mode(nmode), .i_chain_tap_pulse(tap),
    .i_modulus_underflow(mdl), .i_counter_wrap(cw), .i_accum_wrap(aw), .i_accum_edge(ae),
    .o_periodic_tick(tick), .o_irq(irq), .o_ctrl(ctl));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task results;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle; optional wrap pulse sampled on the write edge
  task bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic ev);
    int n;
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, {idx[5:0], 2'b00}, 4'h1, {24'h0, d}};
    cw <= ev;
    n = 0;
    do begin
      @(posedge clk);
      cw <= 1'b0;
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat[7:0];
    wb <= '0;
    if (n >= 20) begin
      err_count++;
      results();
    end
  endtask

  task rdc(input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 1'b0);
    chk({24'h0, rd}, {24'h0, e});
  endtask

  task rst;
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
  endtask

  task evp(input logic [2:0] e);
    @(posedge clk);
    {cw, aw, ae} <= e;
    @(posedge clk);
    {cw, aw, ae} <= 3'h0;
  endtask

  // Selected source pulses on slot 0, the other source on slot 2
  task run(input logic s, input logic [1:0] c, input int n, input logic first);
    int k, p, seen;
    sense <= s;
    seen = 0;
    p = 0;
    bus(1'b1, `PIT_IDX_CTRL, {6'h0, c}, 1'b0);
    repeat (4) @(posedge clk);
    for (k = 0; k < 4 * (2 * n + 3); k++) begin
      @(posedge clk);
      if (k % 4 == 1) p++;
      tap <= (k % 4 == (s ? 2 : 0));
      mdl <= (k % 4 == (s ? 0 : 2));
      @(negedge clk);
      if (tick === 1'b1) begin
        if (seen > 0 || first) chk(p, n);
        seen++;
        p = 0;
      end
    end
    chk({31'h0, seen > 1}, 32'h1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rdc(`PIT_IDX_MASK, 8'h00);
    rdc(`PIT_IDX_FLAGS, 8'h00);
    rdc(`PIT_IDX_CTRL, 8'h00);
    rdc(8'h30, 8'h00);
    chk({28'h0, irq}, 32'h0);
    chk({26'h0, ctl}, 32'h0);
    $display("t_reset done");
  endtask

  task t_flags;
    evp(3'b111);
    rdc(`PIT_IDX_FLAGS, 8'hb0);
    bus(1'b1, `PIT_IDX_FLAGS, 8'h0f, 1'b0);
    rdc(`PIT_IDX_FLAGS, 8'hb0);
    bus(1'b1, `PIT_IDX_FLAGS, 8'h80, 1'b1);
    rdc(`PIT_IDX_FLAGS, 8'hb0);
    bus(1'b1, `PIT_IDX_FLAGS, 8'h80, 1'b0);
    rdc(`PIT_IDX_FLAGS, 8'h30);
    bus(1'b1, `PIT_IDX_MASK, 8'hff, 1'b0);
    rdc(`PIT_IDX_MASK, 8'hf3);
    chk({28'h0, irq}, 32'h3);
    bus(1'b1, `PIT_IDX_MASK, 8'h80, 1'b0);
    chk({28'h0, irq}, 32'h0);
    evp(3'b100);
    rdc(`PIT_IDX_FLAGS, 8'hb0);
    chk({28'h0, irq}, 32'h8);
    bus(1'b1, `PIT_IDX_FLAGS, 8'hf0, 1'b0);
    rdc(`PIT_IDX_FLAGS, 8'h00);
    chk({28'h0, irq}, 32'h0);
    $display("t_flags done");
  endtask

  task t_ctrl;
    bus(1'b1, `PIT_IDX_CTRL, 8'hff, 1'b0);
    rdc(`PIT_IDX_CTRL, 8'h77);
    chk({26'h0, ctl}, 32'h3c);
    bus(1'b1, `PIT_IDX_CTRL, 8'h44, 1'b0);
    chk({26'h0, ctl}, 32'h24);
    bus(1'b1, `PIT_IDX_CTRL, 8'h30, 1'b0);
    chk({26'h0, ctl}, 32'h18);
    $display("t_ctrl done");
  endtask

  task t_tick;
    int s, c;
    rst();
    run(1'b0, 2'h3, 8, 1'b1);
    for (s = 0; s < 2; s++) begin
      for (c = 0; c < 4; c++) begin
        run(s[0], c[1:0], (s == 1 && c == 3) ? 64 : (1 << c), 1'b0);
      end
    end
    rdc(`PIT_IDX_FLAGS, 8'h40);
    bus(1'b1, `PIT_IDX_MASK, 8'h40, 1'b0);
    chk({28'h0, irq}, 32'h4);
    bus(1'b1, `PIT_IDX_FLAGS, 8'h40, 1'b0);
    chk({28'h0, irq}, 32'h0);
    rdc(`PIT_IDX_FLAGS, 8'h00);
    $display("t_tick done");
  endtask

  task t_presc;
    nmode <= 1'b1;
    rst();
    bus(1'b1, `PIT_IDX_MASK, 8'h01, 1'b0);
    chk({26'h0, ctl}, 32'h01);
    bus(1'b1, `PIT_IDX_MASK, 8'h02, 1'b0);
    rdc(`PIT_IDX_MASK, 8'h01);
    rst();
    repeat (70) @(posedge clk);
    bus(1'b1, `PIT_IDX_MASK, 8'hc3, 1'b0);
    rdc(`PIT_IDX_MASK, 8'hc0);
    nmode <= 1'b0;
    $display("t_presc done");
  endtask

  initial begin
    nrst = 1'b0;
    sense = 1'b0;
    nmode = 1'b0;
    tap = 1'b0;
    mdl = 1'b0;
    {cw, aw, ae} = 3'h0;
    wb = '0;
    err_count = 0;
    checks = 0;
    rst();
    t_reset();
    t_flags();
    t_ctrl();
    t_tick();
    t_presc();
    results();
  end
endmodule
`default_nettype wire
